// File: hdl/brk_sim_defines.vh
// Purpose: Constants for the breakpoint and break-status block
// Assumes: Avalon-MM word addressing, 8-bit registers in low byte
// Notes: Offsets are word indices on a 3-bit address
`ifndef BRK_SIM_DEFINES_VH
`define BRK_SIM_DEFINES_VH
`define OFS_BREAK_EXIT_STATUS 3'h0
`define OFS_RESET_CAUSE_STATUS 3'h1
`define OFS_BREAK_FLAG_CONTROL 3'h2
`define OFS_BREAKPOINT_CONTROL_STATUS 3'h3
`define OFS_BREAKPOINT_ADDR_HIGH 3'h4
`define OFS_BREAKPOINT_ADDR_LOW 3'h5
`define OFS_CORE_STATUS 3'h6
`define BIT_EXITED_LOW_POWER 1
`define BIT_CLEAR_ENABLE 7
`define BIT_BREAKPOINT_ENABLE 7
`define BIT_BREAK_ACTIVE 6
`define CAUSE_POWER_ON 7
`define CAUSE_PIN 6
`define CAUSE_WATCHDOG 5
`define CAUSE_BAD_OPCODE 4
`define CAUSE_BAD_FETCH 3
`define CAUSE_LOW_VOLTAGE 1
`define VEC_NORMAL 16'hFFFC
`define VEC_MONITOR 16'hFEFC
`define BYTE_ZERO 8'h00
`define ADDR_ZERO 16'h0000
`define CNT_ZERO 12'h000
`define CNT_ONE 12'h001
`endif

// File: hdl/addr_match.v
// Purpose: Breakpoint address comparator
// Assumes: Same clock as the CPU address bus
// Notes: Registered match pulse
`timescale 1ns/1ps
`default_nettype none
module addr_match #(
    parameter AW = 16
) (
    input wire mclk_i,
    input wire rst_i,
    input wire [AW-1:0] bus_addr_i,
    input wire [AW-1:0] brk_addr_i,
    input wire valid_i,
    output reg hit_o
);
    always @(posedge mclk_i)
    begin
        if (rst_i)
            hit_o <= 1'b0;
        else
            hit_o <= valid_i && (bus_addr_i == brk_addr_i);
    end
endmodule // addr_match
`default_nettype wire

// File: hdl/brk_sim.v
// What this block does
// - Break ending stop sets exited-low-power flag
// - Recovery counter cleared in stop, then counts
// - Exited flag cleared by zero write, reset
// - Six reset-cause flags, cleared on read
// - Power-on reset sets power-on flag
// - Set only the flag of last cause
// - In break, clears allowed only if enabled
// - Address match raises breakpoint to CPU
// - Vector FFFC, or FEFC in monitor mode
// - Writing one to break-active forces break
// - Match on last cycle breaks immediately
// - Trap return ends the break state
// - Timer counter halted during break
// - Watchdog off in break under test voltage
// - Breakpoint stays active in wait mode
// - Inactive in stop, registers kept
// - Enable bit 7 gates match, reset clears
// - Match sets break-active; software clears it
// - Address high/low bytes, reset clears both
// - Break in wait sets same flag
// - Two-step clears begun before break held off until break ends
// Purpose: Breakpoint unit with break-exit, reset-cause and flag-control registers
// Assumes: CPU core signals on mclk_i; reset cause inputs are synchronous pulses
// Notes: Avalon-MM slave, one wait state on every access
`timescale 1ns/1ps
`default_nettype none
`include "brk_sim_defines.vh"
module brk_sim #(
    parameter AW = 16,
    parameter CW = 12
) (
    input wire mclk_i,
    input wire rst_i,
    input wire [2:0] address_i,
    input wire read_i,
    input wire write_i,
    input wire [31:0] writedata_i,
    output reg [31:0] readdata_o,
    output reg waitrequest_o,
    input wire [AW-1:0] cpu_addr_i,
    input wire cpu_addr_valid_i,
    input wire cpu_last_cycle_i,
    input wire cpu_trap_return_i,
    input wire stop_exec_i,
    input wire wait_exec_i,
    input wire wake_i,
    input wire monitor_mode_i,
    input wire test_voltage_i,
    input wire cause_power_on_i,
    input wire cause_pin_i,
    input wire cause_watchdog_i,
    input wire cause_bad_opcode_i,
    input wire cause_bad_fetch_i,
    input wire cause_low_voltage_i,
    input wire step1_seen_i,
    output reg break_req_o,
    output reg [AW-1:0] break_vector_o,
    output reg break_state_o,
    output reg flag_clear_ok_o,
    output reg second_step_ok_o,
    output reg timer_halt_o,
    output reg watchdog_off_o,
    output reg [CW-1:0] recovery_count_o
);
    localparam MODE_RUN = 2'b00;
    localparam MODE_WAIT = 2'b01;
    localparam MODE_STOP = 2'b10;
    localparam MODE_RECOVER = 2'b11;

    reg [1:0] mode_reg;
    reg [1:0] mode_next;
    reg exited_reg;
    reg [7:0] cause_reg;
    reg clear_enable_reg;
    reg brk_enable_reg;
    reg brk_active_reg;
    reg [7:0] addr_high_reg;
    reg [7:0] addr_low_reg;
    reg in_break_reg;
    reg pending_reg;
    reg test_meta_reg;
    reg test_sync_reg;
    reg step1_pre_reg;
    reg phase_reg;
    reg [7:0] rdata_next;
    wire hit;
    wire any_cause;
    wire acc_go;
    wire wr_go;
    wire rd_go;
    wire force_break;
    wire match_break;
    wire break_start;
    wire [AW-1:0] brk_addr;

    assign brk_addr = {addr_high_reg, addr_low_reg};
    assign acc_go = (read_i || write_i) && phase_reg;
    assign wr_go = write_i && phase_reg;
    assign rd_go = read_i && phase_reg;
    assign any_cause = cause_power_on_i || cause_pin_i || cause_watchdog_i ||
        cause_bad_opcode_i || cause_bad_fetch_i || cause_low_voltage_i;

    addr_match #(
        .AW(AW)
    ) u_match (
        .mclk_i(mclk_i),
        .rst_i(rst_i),
        .bus_addr_i(cpu_addr_i),
        .brk_addr_i(brk_addr),
        .valid_i(cpu_addr_valid_i && brk_enable_reg && (mode_reg != MODE_STOP)),
        .hit_o(hit)
    );

    // Break on match or forced write of one
    assign match_break = hit && brk_enable_reg;
    assign force_break = wr_go && (address_i == `OFS_BREAKPOINT_CONTROL_STATUS) &&
        writedata_i[`BIT_BREAK_ACTIVE];
    assign break_start = !in_break_reg &&
        ((pending_reg && cpu_last_cycle_i) || force_break ||
        (match_break && cpu_last_cycle_i));

    // Test-voltage pin synchroniser
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            test_meta_reg <= 1'b0;
            test_sync_reg <= 1'b0;
        end
        else
        begin
            test_meta_reg <= test_voltage_i;
            test_sync_reg <= test_meta_reg;
        end
    end

    // Bus handshake: one wait state
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            phase_reg <= 1'b0;
            waitrequest_o <= 1'b1;
        end
        else if (acc_go)
        begin
            phase_reg <= 1'b0;
            waitrequest_o <= 1'b1;
        end
        else if (read_i || write_i)
        begin
            phase_reg <= 1'b1;
            waitrequest_o <= 1'b0;
        end
        else
        begin
            phase_reg <= 1'b0;
            waitrequest_o <= 1'b1;
        end
    end

    always @*
    begin
        rdata_next = `BYTE_ZERO;
        case (address_i)
            `OFS_BREAK_EXIT_STATUS:
                rdata_next[`BIT_EXITED_LOW_POWER] = exited_reg;
            `OFS_RESET_CAUSE_STATUS:
                rdata_next = cause_reg;
            `OFS_BREAK_FLAG_CONTROL:
                rdata_next[`BIT_CLEAR_ENABLE] = clear_enable_reg;
            `OFS_BREAKPOINT_CONTROL_STATUS:
            begin
                rdata_next[`BIT_BREAKPOINT_ENABLE] = brk_enable_reg;
                rdata_next[`BIT_BREAK_ACTIVE] = brk_active_reg;
            end
            `OFS_BREAKPOINT_ADDR_HIGH:
                rdata_next = addr_high_reg;
            `OFS_BREAKPOINT_ADDR_LOW:
                rdata_next = addr_low_reg;
            `OFS_CORE_STATUS:
                rdata_next = {6'h00, mode_reg};
            default:
                rdata_next = `BYTE_ZERO;
        endcase
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
            readdata_o <= 32'h00000000;
        else if (read_i && !phase_reg)
            readdata_o <= {24'h000000, rdata_next};
        else
            readdata_o <= readdata_o;
    end

    // Low-power mode tracking
    always @*
    begin
        case (mode_reg)
            MODE_RUN:
                if (stop_exec_i)
                    mode_next = MODE_STOP;
                else if (wait_exec_i)
                    mode_next = MODE_WAIT;
                else
                    mode_next = MODE_RUN;
            MODE_WAIT:
                if (wake_i || break_start)
                    mode_next = MODE_RUN;
                else
                    mode_next = MODE_WAIT;
            MODE_STOP:
                if (wake_i || force_break)
                    mode_next = MODE_RECOVER;
                else
                    mode_next = MODE_STOP;
            MODE_RECOVER:
                if (recovery_count_o == {CW{1'b1}})
                    mode_next = MODE_RUN;
                else
                    mode_next = MODE_RECOVER;
            default:
                mode_next = MODE_RUN;
        endcase
    end

    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            mode_reg <= MODE_RUN;
            recovery_count_o <= {CW{1'b0}};
        end
        else
        begin
            mode_reg <= mode_next;
            if (mode_reg == MODE_STOP || stop_exec_i)
                recovery_count_o <= {CW{1'b0}};
            else if (mode_reg == MODE_RECOVER)
                recovery_count_o <= recovery_count_o + {{(CW-1){1'b0}}, 1'b1};
            else
                recovery_count_o <= recovery_count_o;
        end
    end

    // Reset-cause register; rst_i does not clear it
    always @(posedge mclk_i)
    begin
        if (any_cause)
        begin
            cause_reg <= `BYTE_ZERO;
            cause_reg[`CAUSE_POWER_ON] <= cause_power_on_i;
            cause_reg[`CAUSE_PIN] <= cause_pin_i;
            cause_reg[`CAUSE_WATCHDOG] <= cause_watchdog_i;
            cause_reg[`CAUSE_BAD_OPCODE] <= cause_bad_opcode_i;
            cause_reg[`CAUSE_BAD_FETCH] <= cause_bad_fetch_i;
            cause_reg[`CAUSE_LOW_VOLTAGE] <= cause_low_voltage_i;
        end
        else if (rd_go && address_i == `OFS_RESET_CAUSE_STATUS)
            cause_reg <= `BYTE_ZERO;
        else
            cause_reg <= cause_reg;
    end

    // Software registers and break state
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            exited_reg <= 1'b0;
            clear_enable_reg <= 1'b0;
            brk_enable_reg <= 1'b0;
            brk_active_reg <= 1'b0;
            addr_high_reg <= `BYTE_ZERO;
            addr_low_reg <= `BYTE_ZERO;
            in_break_reg <= 1'b0;
            pending_reg <= 1'b0;
        end
        else
        begin
            if (wr_go && address_i == `OFS_BREAK_FLAG_CONTROL)
                clear_enable_reg <= writedata_i[`BIT_CLEAR_ENABLE];
            if (wr_go && address_i == `OFS_BREAKPOINT_ADDR_HIGH)
                addr_high_reg <= writedata_i[7:0];
            if (wr_go && address_i == `OFS_BREAKPOINT_ADDR_LOW)
                addr_low_reg <= writedata_i[7:0];
            if (wr_go && address_i == `OFS_BREAKPOINT_CONTROL_STATUS)
                brk_enable_reg <= writedata_i[`BIT_BREAKPOINT_ENABLE];
            // Set wins over software clear
            if (match_break || force_break)
                brk_active_reg <= 1'b1;
            else if (wr_go && address_i == `OFS_BREAKPOINT_CONTROL_STATUS &&
                !writedata_i[`BIT_BREAK_ACTIVE])
                brk_active_reg <= 1'b0;
            if (break_start && (mode_reg == MODE_WAIT || mode_reg == MODE_STOP ||
                mode_reg == MODE_RECOVER))
                exited_reg <= 1'b1;
            else if (wr_go && address_i == `OFS_BREAK_EXIT_STATUS &&
                !writedata_i[`BIT_EXITED_LOW_POWER])
                exited_reg <= 1'b0;
            if (break_start || in_break_reg)
                pending_reg <= 1'b0;
            else if (match_break && !cpu_last_cycle_i)
                pending_reg <= 1'b1;
            if (break_start)
                in_break_reg <= 1'b1;
            else if (cpu_trap_return_i)
                in_break_reg <= 1'b0;
        end
    end

    // First step seen before break stays blocked while in break
    always @(posedge mclk_i)
    begin
        if (rst_i)
            step1_pre_reg <= 1'b0;
        else if (!in_break_reg)
            step1_pre_reg <= step1_seen_i;
        else
            step1_pre_reg <= step1_pre_reg;
    end

    // Registered outputs to the CPU and other modules
    always @(posedge mclk_i)
    begin
        if (rst_i)
        begin
            break_req_o <= 1'b0;
            break_vector_o <= `ADDR_ZERO;
            break_state_o <= 1'b0;
            flag_clear_ok_o <= 1'b1;
            second_step_ok_o <= 1'b1;
            timer_halt_o <= 1'b0;
            watchdog_off_o <= 1'b0;
        end
        else
        begin
            break_req_o <= break_start;
            break_vector_o <= monitor_mode_i ? `VEC_MONITOR : `VEC_NORMAL;
            break_state_o <= in_break_reg || break_start;
            flag_clear_ok_o <= !(in_break_reg || break_start) || clear_enable_reg;
            second_step_ok_o <= !(in_break_reg || break_start) ||
                (clear_enable_reg && !step1_pre_reg);
            timer_halt_o <= in_break_reg || break_start;
            watchdog_off_o <= (in_break_reg || break_start) && test_sync_reg;
        end
    end
endmodule // brk_sim
`default_nettype wire

// File: dv/brk_sim_props.sv
// Purpose: Port checker for the break unit
// Assumes: One clock, sync reset
// Notes: Bound into brk_sim
`timescale 1ns/1ps
`default_nettype none
`include "brk_sim_defines.vh"
module brk_sim_props (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic read_i,
    input wire logic write_i,
    input wire logic waitrequest_o,
    input wire logic monitor_mode_i,
    input wire logic test_voltage_i,
    input wire logic cpu_trap_return_i,
    input wire logic break_req_o,
    input wire logic [15:0] break_vector_o,
    input wire logic break_state_o,
    input wire logic timer_halt_o,
    input wire logic watchdog_off_o
);
    default clocking @(posedge mclk_i);
    endclocking
    default disable iff (rst_i);
    sequence s_req;
        (read_i || write_i) && waitrequest_o;
    endsequence
    sequence s_tv_brk;
        (break_state_o && test_voltage_i)[*4];
    endsequence
    sequence s_tv_low;
        (!test_voltage_i)[*4];
    endsequence
    bus_ans_a: assert property (s_req |=> !waitrequest_o)
        else $error("bus answer missing");
    wait_one_a: assert property (!waitrequest_o |=> waitrequest_o)
        else $error("wait low too long");
    req_pulse_a: assert property (break_req_o |=> !break_req_o)
        else $error("break request not a pulse");
    req_state_a: assert property (break_req_o |-> break_state_o)
        else $error("request outside break");
    vec_sel_a: assert property (!$past(rst_i) |-> break_vector_o ==
        ($past(monitor_mode_i) ? `VEC_MONITOR : `VEC_NORMAL)) else $error("bad vector");
    halt_track_a: assert property (timer_halt_o == break_state_o)
        else $error("timer halt wrong");
    trap_end_a: assert property (break_state_o && cpu_trap_return_i |-> ##2 !break_state_o)
        else $error("break not ended");
    wd_off_a: assert property (s_tv_brk |-> watchdog_off_o)
        else $error("watchdog not off");
    wd_need_a: assert property (s_tv_low |-> !watchdog_off_o)
        else $error("watchdog off without voltage");
endmodule // brk_sim_props
bind brk_sim brk_sim_props u_props (.mclk_i(mclk_i), .rst_i(rst_i), .read_i(read_i),
    .write_i(write_i), .waitrequest_o(waitrequest_o), .monitor_mode_i(monitor_mode_i),
    .test_voltage_i(test_voltage_i), .cpu_trap_return_i(cpu_trap_return_i),
    .break_req_o(break_req_o), .break_vector_o(break_vector_o), .break_state_o(break_state_o),
    .timer_halt_o(timer_halt_o), .watchdog_off_o(watchdog_off_o));
`default_nettype wire

// File: dv/cpu_model.sv
// Purpose: CPU core stand-in on the address bus
// Assumes: One or four cycles per instruction
// Notes: Jumps to the vector on a break request
`timescale 1ns/1ps
`default_nettype none
module cpu_model (
    input wire logic mclk_i,
    input wire logic rst_i,
    input wire logic load_i,
    input wire logic [15:0] pc_i,
    input wire logic slow_i,
    input wire logic ret_i,
    input wire logic brk_i,
    input wire logic [15:0] vec_i,
    output logic [15:0] addr_o,
    output logic valid_o,
    output logic last_o,
    output logic ret_o
);
    logic [1:0] cnt_reg;
    assign valid_o = 1'b1;
    assign last_o = !slow_i || cnt_reg == 2'h3;
    always @(posedge mclk_i)
    begin
        ret_o <= ret_i && !rst_i;
        cnt_reg <= rst_i ? 2'h0 : cnt_reg + 2'h1;
        if (rst_i)
            addr_o <= 16'h0000;
        else if (brk_i)
            addr_o <= vec_i;
        else if (load_i)
            addr_o <= pc_i;
        else
            addr_o <= addr_o + 16'h0001;
    end
endmodule // cpu_model
`default_nettype wire

// File: dv/tb_brk_sim.sv
// Purpose: Self-checking bench for the break unit
// Assumes: CPU stand-in on the core side
// Notes: Recovery counter cut to 4 bits
`timescale 1ns/1ps
`default_nettype none
`include "brk_sim_defines.vh"
module tb_brk_sim;
    logic mclk_i = 1'b0, rst_i = 1'b1, rd = 1'b0, wr = 1'b0, mon = 1'b0, tv = 1'b0;
    logic stp = 1'b0, wt = 1'b0, s1 = 1'b0, ld = 1'b0, slow = 1'b0, ret = 1'b0, f;
    logic [2:0] adr = 3'h0;
    logic [5:0] cz = 6'h00;
    logic [31:0] wd = 32'h0, rdo, q;
    logic [15:0] pc = 16'h0000, a, cpa, vec;
    logic wrq, req, bst, fok, sok, thl, wdo, cval, clast, cret;
    logic [3:0] rcnt;
    int failures = 0, cmp_count = 0, i, m, wn;
    brk_sim #(.CW(4)) u_dut (.mclk_i(mclk_i), .rst_i(rst_i), .address_i(adr), .read_i(rd),
        .write_i(wr), .writedata_i(wd), .readdata_o(rdo), .waitrequest_o(wrq), .cpu_addr_i(cpa),
        .cpu_addr_valid_i(cval), .cpu_last_cycle_i(clast), .cpu_trap_return_i(cret),
        .stop_exec_i(stp), .wait_exec_i(wt), .wake_i(1'b0), .monitor_mode_i(mon),
        .test_voltage_i(tv), .cause_power_on_i(cz[5]), .cause_pin_i(cz[4]),
        .cause_watchdog_i(cz[3]), .cause_bad_opcode_i(cz[2]), .cause_bad_fetch_i(cz[1]),
        .cause_low_voltage_i(cz[0]), .step1_seen_i(s1), .break_req_o(req), .break_vector_o(vec),
        .break_state_o(bst), .flag_clear_ok_o(fok), .second_step_ok_o(sok), .timer_halt_o(thl),
        .watchdog_off_o(wdo), .recovery_count_o(rcnt));
    cpu_model u_cpu (.mclk_i(mclk_i), .rst_i(rst_i), .load_i(ld), .pc_i(pc), .slow_i(slow),
        .ret_i(ret), .brk_i(req), .vec_i(vec), .addr_o(cpa), .valid_o(cval), .last_o(clast),
        .ret_o(cret));
    initial forever #12.5 mclk_i = ~mclk_i;
    function automatic logic [31:0] cbit(input int k);
        return (k < 5) ? 32'h80 >> k : 32'h02;
    endfunction
    task automatic tk(input int n);
        repeat (n) @(posedge mclk_i);
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        cmp_count++;
        if (g !== e)
        begin
            failures++;
            $display("[ERR] t=%0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic bus(input logic w, input logic [2:0] ad, input logic [31:0] d);
        @(posedge mclk_i);
        rd <= !w;
        wr <= w;
        adr <= ad;
        wd <= d;
        @(posedge mclk_i);
        while (wrq !== 1'b0)
        begin
            @(posedge mclk_i);
        end
        q = rdo;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask
    task automatic rk(input logic [2:0] ad, input logic [31:0] e);
        bus(1'b0, ad, 32'h0);
        chk(q, e);
    endtask
    task automatic wbrk(input int lim);
        int n;
        for (n = 0; n < lim; n++)
        begin
            @(posedge mclk_i);
            if (req === 1'b1)
                break;
        end
        f = (n < lim);
        wn = n;
    endtask
    task automatic jump();
        pc <= a - 16'h0003;
        ld <= 1'b1;
        tk(1);
        ld <= 1'b0;
    endtask
    task automatic trap_ret();
        ret <= 1'b1;
        tk(1);
        ret <= 1'b0;
        tk(3);
    endtask
    task automatic finish_test();
        $display("Comparisons %0d, mismatches %0d", cmp_count, failures);
        if (failures == 0 && cmp_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial
    begin
        #500000;
        failures++;
        finish_test();
    end
    initial
    begin
        i = $urandom(32'h6A84);
        tk(20);
        rst_i <= 1'b0;
        rk(3'h0, 32'h0);
        for (i = 3; i < 6; i++)
            rk(3'(i), 32'h0);
        bus(1'b1, 3'h7, 32'hFF);
        rk(3'h7, 32'h0);
        for (i = 0; i < 6; i++)
        begin
            cz <= 6'h20 >> i;
            tk(1);
            cz <= 6'h00;
            rk(3'h1, cbit(i));
            rk(3'h1, 32'h0);
        end
        s1 <= 1'b1;
        for (m = 0; m < 2; m++)
        begin
            mon <= m[0];
            slow <= (m == 0) ? 1'b0 : 1'($urandom);
            a = 16'h0100 + 16'($urandom % 32'h7000);
            bus(1'b1, 3'h2, 32'(m) << 7);
            bus(1'b1, 3'h4, 32'(a[15:8]));
            bus(1'b1, 3'h5, 32'(a[7:0]));
            bus(1'b1, 3'h3, 32'h80);
            rk(3'h4, 32'(a[15:8]));
            rk(3'h5, 32'(a[7:0]));
            jump();
            wbrk(40);
            chk(f, 1);
            if (m == 0) chk(wn, 5);
            tk(1);
            chk(cpa, m ? `VEC_MONITOR : `VEC_NORMAL);
            chk(thl, 1);
            chk(fok, m);
            chk(sok, 0);
            rk(3'h3, 32'hC0);
            tv <= 1'b1;
            tk(6);
            chk(wdo, 1);
            tv <= 1'b0;
            bus(1'b1, 3'h3, 32'h0);
            rk(3'h3, 32'h0);
            trap_ret();
            chk(bst, 0);
            chk(sok, 1);
        end
        jump();
        wbrk(20);
        chk(f, 0);
        wt <= 1'b1;
        tk(1);
        wt <= 1'b0;
        rk(3'h6, 32'h1);
        bus(1'b1, 3'h3, 32'h40);
        wbrk(5);
        chk(f, 1);
        rk(3'h0, 32'h2);
        bus(1'b1, 3'h3, 32'h0);
        trap_ret();
        bus(1'b1, 3'h0, 32'h0);
        rk(3'h0, 32'h0);
        bus(1'b1, 3'h0, 32'h2);
        rk(3'h0, 32'h0);
        bus(1'b1, 3'h3, 32'h80);
        stp <= 1'b1;
        tk(1);
        stp <= 1'b0;
        tk(2);
        chk(rcnt, 0);
        jump();
        wbrk(20);
        chk(f, 0);
        rk(3'h4, 32'(a[15:8]));
        bus(1'b1, 3'h3, 32'hC0);
        wbrk(5);
        chk(f, 1);
        tk(2);
        chk(rcnt != 4'h0, 1);
        rk(3'h6, 32'h3);
        rk(3'h0, 32'h2);
        bus(1'b1, 3'h3, 32'h0);
        trap_ret();
        finish_test();
    end
endmodule // tb_brk_sim
`default_nettype wire
